// ==== inc/ds3_rx_sync_cfg.svh ====
// Offsets, field positions, reset values and counts of the DS3 receive sync block.
// Assumes a 32-bit Avalon-MM slave with byte addresses; each register takes one word.
`ifndef DS3_RX_SYNC_CFG_SVH
`define DS3_RX_SYNC_CFG_SVH

// ********************************************************************
// Register indices; the byte address is four times the index.
// ********************************************************************
`define ADDR_W          14
`define IDX_CFG         12'h310
`define IDX_FAR_STATUS  12'h311
`define IDX_INT_ENABLE  12'h312
`define IDX_INT_STATUS  12'h313

// ********************************************************************
// Field positions.
// ********************************************************************
`define CFG_PSEL        2
`define CFG_FSEL        1
`define CFG_MSEL        0
`define CFG_AIS         7
`define CFG_LOS         6
`define CFG_IDLE        5
`define CFG_OOF         4
`define FAR_FERF        4
`define FAR_AIC         3
`define EV_CP           7
`define EV_LOS          6
`define EV_AIS          5
`define EV_IDLE         4
`define EV_FERF         3
`define EV_AIC          2
`define EV_OOF          1
`define EV_PERR         0

// ********************************************************************
// Reset values and counts.
// ********************************************************************
`define CFG_RW_RESET    3'h2
`define EN_RESET        8'h00
`define FEBE_RESET      3'h0
`define AIC_ZERO_RUN    6'h02
`define AIC_ONE_RUN     6'h3F
`define F_WIN           15
`define F_THR_LOOSE     4'h6
`define F_THR_STRICT    4'h3
`define M_WIN           4
`define M_THR           3'h3

`endif

// ==== inc/ds3_rx_sync_pkg.sv ====
// Types shared by the DS3 receive sync block and its out-of-frame monitor.
// Assumes the constants header is included by the files that need numbers.
package ds3_rx_sync_pkg;

    // ********************************************************************
    // Synchronizer states, one-hot.
    // ********************************************************************
    typedef enum logic [3:0] {
        SEARCH_F = 4'h1,
        SEARCH_M = 4'h2,
        CHECK_P  = 4'h4,
        IN_FRAME = 4'h8
    } sync_state_e;

    typedef logic [7:0] byte_t;

endpackage

// ==== inc/oof_if.sv ====
// Interface between the sync controller and its out-of-frame monitor.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface oof_if;
    logic fValid;
    logic fError;
    logic mValid;
    logic mError;
    logic fStrict;
    logic mEnable;
    logic clearWin;
    logic oofDetect;

    modport ctrl (output fValid, fError, mValid, mError, fStrict, mEnable, clearWin,
                  input oofDetect);
    modport mon  (input fValid, fError, mValid, mError, fStrict, mEnable, clearWin,
                  output oofDetect);
endinterface

// ==== src/ds3_rx_frame_sync_alarms.sv ====
// DS3 receive frame sync control, alarm status and event latching for one channel.
// Assumes framer strobes arrive on clk; registers are reached over Avalon-MM.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ns
`include "ds3_rx_sync_cfg.svh"

module ds3_rx_frame_sync_alarms
    import ds3_rx_sync_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic [`ADDR_W-1:0] address,
    input  wire logic               read,
    input  wire logic               write,
    input  wire logic [31:0]        writedata,
    input  wire logic [3:0]         byteenable,
    output logic      [31:0]        readdata,
    output logic                    waitrequest,
    output logic                    irq,
    output logic                    outOfFrame,
    input  wire logic               e3Mode,
    input  wire logic               syncBypass,
    input  wire logic               cbitParity,
    input  wire logic               fAligned,
    input  wire logic               mAligned,
    input  wire logic               fBitValid,
    input  wire logic               fBitError,
    input  wire logic               frameValid,
    input  wire logic               mBitError,
    input  wire logic               pBitError,
    input  wire logic               cpBitError,
    input  wire logic               appIdBit,
    input  wire logic [2:0]         febeCode,
    input  wire logic               lossOfSignal,
    input  wire logic               alarmIndication,
    input  wire logic               idleDetect,
    input  wire logic               farEndFailure
);

    sync_state_e state_reg;
    logic [2:0]  cfg_reg;
    byte_t       intEnable_reg;
    byte_t       intStatus_reg;
    byte_t       intStatus_next;
    byte_t       eventVec;
    logic [2:0]  febe_reg;
    logic        appId_reg;
    logic        appIdOld_reg;
    logic [5:0]  zeroRun_reg;
    logic [5:0]  oneRun_reg;
    logic        los_reg;
    logic        ais_reg;
    logic        idle_reg;
    logic        ferf_reg;
    logic        oof_reg;
    logic        pChkEff;
    logic        busReq;
    logic        accept;
    logic        statusRead;
    oof_if       oofBus();

    oof_monitor u_oof_monitor (
        .clk    (clk),
        .resetn (resetn),
        .ifc    (oofBus.mon)
    );

    // Matches a word-aligned byte address against a register index.
    function automatic logic hitIdx(input logic [`ADDR_W-1:0] a, input logic [11:0] idx);
        return a == {idx, 2'b00};
    endfunction

    // ********************************************************************
    // Frame acquisition.
    // ********************************************************************
    assign pChkEff = cfg_reg[`CFG_PSEL] && !e3Mode && !syncBypass;

    // The monitor gets the loose F criterion in E3 or bypass, and no M criterion in E3.
    assign oofBus.fValid   = fBitValid;
    assign oofBus.fError   = fBitError;
    assign oofBus.mValid   = frameValid;
    assign oofBus.mError   = mBitError;
    assign oofBus.fStrict  = cfg_reg[`CFG_FSEL] && !e3Mode && !syncBypass;
    assign oofBus.mEnable  = cfg_reg[`CFG_MSEL] && !e3Mode;
    assign oofBus.clearWin = state_reg != IN_FRAME;

    // A failed P-bit check sends the search back to the start.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            state_reg <= SEARCH_F;
        else
            case (state_reg)
                SEARCH_F: if (fAligned) state_reg <= SEARCH_M;
                SEARCH_M: if (mAligned) state_reg <= pChkEff ? CHECK_P : IN_FRAME;
                CHECK_P:  if (frameValid) state_reg <= pBitError ? SEARCH_F : IN_FRAME;
                IN_FRAME: if (oofBus.oofDetect) state_reg <= SEARCH_F;
                default:  state_reg <= SEARCH_F;
            endcase
    end

    // Out-of-frame follows the state one cycle later.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            outOfFrame <= 1'b1;
        else
            outOfFrame <= state_reg != IN_FRAME;
    end

    // ********************************************************************
    // Far-end and application-ID tracking.
    // ********************************************************************
    // The code is only refreshed when it means something.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            febe_reg <= `FEBE_RESET;
        else if (frameValid && cbitParity && !e3Mode && !syncBypass)
            febe_reg <= febeCode;
    end

    // Run counters saturate so a long run cannot wrap into a false change.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            zeroRun_reg <= 6'h00;
            oneRun_reg  <= 6'h00;
            appId_reg   <= 1'b0;
        end
        else if (frameValid && !e3Mode)
        begin
            zeroRun_reg <= appIdBit ? 6'h00 : zeroRun_reg + {5'h00, zeroRun_reg != `AIC_ONE_RUN};
            oneRun_reg  <= appIdBit ? oneRun_reg + {5'h00, oneRun_reg != `AIC_ONE_RUN} : 6'h00;
            if (!appIdBit && zeroRun_reg == `AIC_ZERO_RUN - 6'h01)
                appId_reg <= 1'b0;
            else if (appIdBit && oneRun_reg == `AIC_ONE_RUN - 6'h01)
                appId_reg <= 1'b1;
        end
    end

    // ********************************************************************
    // Event detection.
    // ********************************************************************
    // Delayed copies of the alarm levels give edge detection both ways.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            los_reg  <= 1'b0;
            ais_reg  <= 1'b0;
            idle_reg <= 1'b0;
            ferf_reg <= 1'b0;
            oof_reg  <= 1'b1;
            appIdOld_reg <= 1'b0;
        end
        else
        begin
            los_reg  <= lossOfSignal;
            ais_reg  <= alarmIndication;
            idle_reg <= idleDetect;
            ferf_reg <= farEndFailure;
            oof_reg  <= outOfFrame;
            appIdOld_reg <= appId_reg;
        end
    end

    // Events of the bypassed synchronizer are dropped at the source.
    always_comb
    begin
        eventVec = 8'h00;
        eventVec[`EV_CP]   = cpBitError && frameValid && cbitParity && !e3Mode;
        eventVec[`EV_LOS]  = lossOfSignal != los_reg;
        eventVec[`EV_AIS]  = (alarmIndication != ais_reg) && !syncBypass;
        eventVec[`EV_IDLE] = (idleDetect != idle_reg) && !syncBypass;
        eventVec[`EV_FERF] = (farEndFailure != ferf_reg) && !syncBypass;
        eventVec[`EV_AIC]  = (appId_reg != appIdOld_reg) && !syncBypass;
        eventVec[`EV_OOF]  = (outOfFrame != oof_reg) && !syncBypass;
        eventVec[`EV_PERR] = pBitError && frameValid && !syncBypass;
    end

    // ********************************************************************
    // Avalon-MM slave.
    // ********************************************************************
    // Every access waits one cycle, which keeps read data registered.
    assign busReq     = read || write;
    assign accept     = busReq && !waitrequest;
    assign statusRead = accept && read && hitIdx(address, `IDX_INT_STATUS);

    always_ff @(posedge clk)
    begin
        if (!resetn || accept)
            waitrequest <= 1'b1;
        else if (busReq)
            waitrequest <= 1'b0;
    end

    // Read data is sampled while the answer stands; unmapped words read zero.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            readdata <= 32'h0000_0000;
        else if (read && waitrequest)
        begin
            readdata <= 32'h0000_0000;
            if (hitIdx(address, `IDX_CFG))
                readdata[7:0] <= {alarmIndication, lossOfSignal, idleDetect, outOfFrame,
                                  1'b0, cfg_reg};
            else if (hitIdx(address, `IDX_FAR_STATUS))
                readdata[7:0] <= {3'h0, farEndFailure, appId_reg, febe_reg};
            else if (hitIdx(address, `IDX_INT_ENABLE))
                readdata[7:0] <= intEnable_reg;
            else if (hitIdx(address, `IDX_INT_STATUS))
                readdata[7:0] <= intStatus_next;
        end
    end

    // Configuration and enables take byte lane 0 only.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cfg_reg       <= `CFG_RW_RESET;
            intEnable_reg <= `EN_RESET;
        end
        else if (accept && write && byteenable[0])
        begin
            if (hitIdx(address, `IDX_CFG))
                cfg_reg <= writedata[2:0];
            if (hitIdx(address, `IDX_INT_ENABLE))
                intEnable_reg <= writedata[7:0];
        end
    end

    // ********************************************************************
    // Sticky status and request.
    // ********************************************************************
    // The read clears what was returned; an event in that cycle still sets.
    always_comb
    begin
        intStatus_next = statusRead ? 8'h00 : intStatus_reg;
        intStatus_next = intStatus_next | (eventVec & intEnable_reg);
    end

    // Status bits hold until a read of the status register clears them.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            intStatus_reg <= 8'h00;
        else
            intStatus_reg <= intStatus_next;
    end

    // The request looks at the next status so it rises with the bit it reports.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            irq <= 1'b0;
        else
            irq <= |(intStatus_next & intEnable_reg);
    end

    // ********************************************************************
    // Checks.
    // ********************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_frame_no_pchk: assert property (state_reg == SEARCH_M && mAligned && !pChkEff
                                      |=> state_reg == IN_FRAME ##1 !outOfFrame)
        else $error("In-frame not reached after M search without P check.");
    a_frame_pchk: assert property (state_reg == SEARCH_M && mAligned && pChkEff
                                   |=> state_reg == CHECK_P)
        else $error("P-bit check skipped.");
    a_pchk_ignored: assert property ($rose(state_reg == CHECK_P)
                                     |-> !$past(e3Mode) && !$past(syncBypass))
        else $error("P-bit check entered in E3 or bypass.");
    a_oof_declare: assert property (state_reg == IN_FRAME && oofBus.oofDetect
                                    |=> ##1 outOfFrame)
        else $error("Out-of-frame not declared.");
    a_aic_one: assert property ($rose(appId_reg) |-> $past(oneRun_reg) == 6'h3E)
        else $error("App-ID set before 63 frames.");
    a_febe_hold: assert property (!frameValid |=> $stable(febe_reg))
        else $error("Error code changed without a frame.");
    a_status_set: assert property ((eventVec & intEnable_reg) != 8'h00
                                   |=> (intStatus_reg & $past(eventVec) & $past(intEnable_reg))
                                       == ($past(eventVec) & $past(intEnable_reg)))
        else $error("Enabled event lost.");
    a_status_keep: assert property (!statusRead |=> (intStatus_reg & $past(intStatus_reg))
                                                    == $past(intStatus_reg))
        else $error("Status bit cleared without a read.");
    a_irq_level: assert property ((intStatus_reg & intEnable_reg) != 8'h00 && !statusRead
                                  |=> irq)
        else $error("Request low with enabled status set.");
    a_bus_answer: assert property (busReq && waitrequest |=> !waitrequest)
        else $error("Bus answer late.");
    a_aic_zero: assert property ($fell(appId_reg) |-> $past(zeroRun_reg) == (`AIC_ZERO_RUN - 6'h01))
        else $error("App-ID cleared before two zero frames.");
    a_febe_update: assert property (frameValid && cbitParity && !e3Mode && !syncBypass
                                    |=> febe_reg == $past(febeCode))
        else $error("Error code not taken from the latest frame.");
    a_cp_status: assert property (frameValid && cpBitError && cbitParity && !e3Mode
                                  && intEnable_reg[`EV_CP] |=> intStatus_reg[`EV_CP])
        else $error("Enabled CP-bit error not latched.");
    a_los_status: assert property ($changed(lossOfSignal) && intEnable_reg[`EV_LOS]
                                   |=> intStatus_reg[`EV_LOS])
        else $error("Enabled loss-of-signal change not latched.");
    a_bypass_drop: assert property (syncBypass
                                    |=> (intStatus_reg & ~$past(intStatus_reg) & 8'h3F) == 8'h00)
        else $error("Event of the bypassed synchronizer latched.");

    // Covers mark the main scenarios: P-checked lock, loss of frame, E3 lock and clear-on-read.
    c_locked: cover property (state_reg == CHECK_P ##1 state_reg == IN_FRAME);
    c_e3_lock: cover property (e3Mode && state_reg == SEARCH_M ##1 state_reg == IN_FRAME);
    c_oof_loss: cover property (state_reg == IN_FRAME ##1 state_reg == SEARCH_F);
    c_read_clear: cover property (statusRead && intStatus_reg != 8'h00);
    c_set_on_read: cover property (statusRead && (eventVec & intEnable_reg) != 8'h00);
endmodule

// ==== src/oof_monitor.sv ====
// Sliding windows over F-bit and M-bit errors that flag loss of framing.
// Assumes error samples arrive as one-cycle strobes on the controller's clock.
`timescale 1ns/1ns
`include "ds3_rx_sync_cfg.svh"
module oof_monitor
    import ds3_rx_sync_pkg::*;
(
    input  wire logic clk,
    input  wire logic resetn,
    oof_if.mon        ifc
);

    logic [`F_WIN-1:0] fWin_reg;
    logic [`M_WIN-1:0] mWin_reg;
    logic [3:0]        fCount;
    logic [3:0]        mCount;
    logic [3:0]        fThr;

    // Counts set bits; used for both windows.
    function automatic logic [3:0] popCount(input logic [`F_WIN-1:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < `F_WIN; i++)
            c = c + {3'h0, v[i]};
        return c;
    endfunction

    assign fCount = popCount(fWin_reg);
    assign mCount = popCount({{(`F_WIN-`M_WIN){1'b0}}, mWin_reg});
    assign fThr   = ifc.fStrict ? `F_THR_STRICT : `F_THR_LOOSE;

    // ********************************************************************
    // Error windows.
    // ********************************************************************
    // Windows restart on each new search so stale errors cannot trip a fresh lock.
    always_ff @(posedge clk)
    begin
        if (!resetn || ifc.clearWin)
            fWin_reg <= '0;
        else if (ifc.fValid)
            fWin_reg <= {fWin_reg[`F_WIN-2:0], ifc.fError};
    end

    // The M window holds the last four DS3 frames.
    always_ff @(posedge clk)
    begin
        if (!resetn || ifc.clearWin)
            mWin_reg <= '0;
        else if (ifc.mValid)
            mWin_reg <= {mWin_reg[`M_WIN-2:0], ifc.mError};
    end

    // M-bit errors only count when enabled.
    always_ff @(posedge clk)
    begin
        if (!resetn || ifc.clearWin)
            ifc.oofDetect <= 1'b0;
        else
            ifc.oofDetect <= (fCount >= fThr) || (ifc.mEnable && mCount >= {1'b0, `M_THR});
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_m_disabled: assert property (!ifc.mEnable && !ifc.clearWin && fCount < fThr
                                   |=> !ifc.oofDetect)
        else $error("M-bit errors raised out-of-frame while disabled.");
    a_f_threshold: assert property (!ifc.clearWin && fCount >= fThr |=> ifc.oofDetect)
        else $error("F-bit error count over threshold did not flag.");
endmodule

// ==== testbench/ds3_far_end.sv ====
// Far-end DS3 stream model: search pulses, F-bits and M-frames.
// Assumes its tasks are called by the bench on the block's clock.
`timescale 1ns/1ns
module ds3_far_end
(
    input  wire logic  clk,
    output logic       fAligned,
    output logic       mAligned,
    output logic       fBitValid,
    output logic       fBitError,
    output logic       frameValid,
    output logic [6:0] fields
);
    // ****************************************
    // Stream tasks
    // ****************************************
    // Qualified fields are inverted between strobes so stale values never pass.
    initial
    begin
        {fAligned, mAligned, fBitValid, fBitError, frameValid} = 5'h00;
        fields = 7'h2A;
    end
    task automatic align();
        @(posedge clk);
        fAligned <= 1'b1;
        @(posedge clk);
        fAligned <= 1'b0;
        mAligned <= 1'b1;
        @(posedge clk);
        mAligned <= 1'b0;
    endtask
    task automatic fbit(input logic e);
        @(posedge clk);
        fBitValid <= 1'b1;
        fBitError <= e;
        @(posedge clk);
        fBitValid <= 1'b0;
        fBitError <= ~e;
    endtask
    // Fields are {M error, P error, CP error, app-ID bit, far-end code}.
    task automatic frame(input logic [6:0] v);
        @(posedge clk);
        frameValid <= 1'b1;
        fields <= v;
        @(posedge clk);
        frameValid <= 1'b0;
        fields <= ~v;
    endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the DS3 receive sync block.
// Assumes the far-end stream model and one 100 MHz clock.
`timescale 1ns/1ns
`include "ds3_rx_sync_cfg.svh"
module tb import ds3_rx_sync_pkg::*;;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [`ADDR_W-1:0] address = '0;
    logic [31:0] writedata = '0;
    logic [31:0] readdata;
    logic waitrequest;
    logic irq;
    logic outOfFrame;
    logic e3Mode = 1'b0;
    logic syncBypass = 1'b0;
    logic cbitParity = 1'b0;
    logic [3:0] alarms = 4'h0;
    logic fAligned, mAligned, fBitValid, fBitError, frameValid;
    logic [6:0] fields;
    logic [31:0] rdw;
    logic [31:0] seed = 32'h00018438;
    byte_t expSt = 8'h00;
    byte_t expEn = 8'h00;
    int failures = 0;
    int checked = 0;
    int cycles = 0;

    ds3_rx_frame_sync_alarms u_dut (.clk(clk), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
        .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .outOfFrame(outOfFrame),
        .e3Mode(e3Mode), .syncBypass(syncBypass), .cbitParity(cbitParity),
        .fAligned(fAligned), .mAligned(mAligned), .fBitValid(fBitValid),
        .fBitError(fBitError), .frameValid(frameValid), .mBitError(fields[6]),
        .pBitError(fields[5]), .cpBitError(fields[4]), .appIdBit(fields[3]),
        .febeCode(fields[2:0]), .lossOfSignal(alarms[3]), .alarmIndication(alarms[2]),
        .idleDetect(alarms[1]), .farEndFailure(alarms[0]));
    ds3_far_end u_far (.clk(clk), .fAligned(fAligned), .mAligned(mAligned),
        .fBitValid(fBitValid), .fBitError(fBitError), .frameValid(frameValid),
        .fields(fields));

    // ****************************************
    // Clock, watchdog and helpers
    // ****************************************
    initial
        forever #5 clk = ~clk;
    // A hang is cut short here and counted as a mismatch.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            $display("[ERR] %0t timeout", $time);
            failures++;
            summarize();
        end
    end
    task automatic note(input string m, input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %0t %s: %h not %h", $time, m, g, e);
        end
    endtask
    // Avalon access: held until waitrequest is sampled low; only the watchdog ends a hang.
    task automatic bus(input logic w, input logic [11:0] i, input byte_t d);
        @(posedge clk);
        read <= ~w;
        write <= w;
        address <= {i, 2'b00};
        writedata <= {24'h0, d};
        do
            @(posedge clk);
        while (waitrequest !== 1'b0);
        rdw = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (w && i == `IDX_INT_ENABLE)
            expEn = d;
        if (!w && i == `IDX_INT_STATUS)
            expSt = 8'h00;
    endtask
    task automatic rg(input string m, input logic [11:0] i, input byte_t e);
        bus(1'b0, i, 8'h00);
        note(m, rdw, {24'h0, e});
    endtask
    // Model of the sticky status: only enabled events latch; bypass drops most.
    function automatic void ev(input int b);
        if (expEn[b] && (!syncBypass || b == `EV_LOS))
            expSt[b] = 1'b1;
    endfunction
    function automatic void xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
    endfunction
    task automatic waitOof(input logic v);
        for (int n = 0; n < 12 && outOfFrame !== v; n++)
            @(posedge clk);
        note("oof", {31'h0, outOfFrame}, {31'h0, v});
        @(posedge clk);
        ev(`EV_OOF);
    endtask
    task automatic acq();
        if (outOfFrame === 1'b1)
        begin
            u_far.align();
            waitOof(1'b0);
        end
    endtask
    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        logic [2:0] f;
        byte_t lvl [4] = '{8'h10, 8'h20, 8'h80, 8'h40};
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        note("oof rst", {31'h0, outOfFrame}, 32'h1);
        note("wait rst", {31'h0, waitrequest}, 32'h1);
        rg("cfg rst", `IDX_CFG, 8'h12);
        bus(1'b1, `IDX_FAR_STATUS, 8'hFF);
        rg("far ro", `IDX_FAR_STATUS, 8'h00);
        rg("en rst", `IDX_INT_ENABLE, 8'h00);
        rg("st rst", `IDX_INT_STATUS, 8'h00);
        rg("unmapped", 12'h300, 8'h00);
        bus(1'b1, `IDX_INT_ENABLE, 8'hFF);
        rg("en rw", `IDX_INT_ENABLE, 8'hFF);
        $display("test registers done");
        // With P checking, search completion alone must not bring frame.
        bus(1'b1, `IDX_CFG, 8'h04);
        u_far.align();
        repeat (4) @(posedge clk);
        note("p hold", {31'h0, outOfFrame}, 32'h1);
        u_far.frame(7'h00);
        waitOof(1'b0);
        note("irq set", {31'h0, irq}, 32'h1);
        rg("oof ev", `IDX_INT_STATUS, expSt);
        repeat (2) @(posedge clk);
        note("irq clr", {31'h0, irq}, 32'h0);
        $display("test acquire done");
        // Errors placed so the window must slide exactly 15 bits to declare.
        for (int s = 0; s < 2; s++)
        begin
            bus(1'b1, `IDX_CFG, {6'h0, s[0], 1'b0});
            acq();
            for (int i = 0; i < 16; i++)
                u_far.fbit(i == 0 || i >= (s ? 14 : 11));
            repeat (4) @(posedge clk);
            note("f slide", {31'h0, outOfFrame}, 32'h0);
            u_far.fbit(1'b1);
            waitOof(1'b1);
        end
        $display("test f window done");
        for (int s = 1; s >= 0; s--)
        begin
            bus(1'b1, `IDX_CFG, {7'h0, s[0]});
            acq();
            for (int i = 0; i < 5; i++)
                u_far.frame({s[0] ? ~i[0] : 1'b1, 6'h07});
            repeat (4) @(posedge clk);
            note("m hold", {31'h0, outOfFrame}, 32'h0);
            u_far.frame(7'h47);
            if (s == 1)
                waitOof(1'b1);
        end
        rg("m ev", `IDX_INT_STATUS, expSt);
        $display("test m window done");
        // Each alarm level rises and falls, first normal, then in bypass.
        for (int b = 0; b < 2; b++)
            for (int k = 0; k < 4; k++)
            begin
                syncBypass <= b[0];
                alarms[k] <= 1'b1;
                repeat (3) @(posedge clk);
                ev(k + 3);
                if (b == 0)
                    rg("lvl", k == 0 ? `IDX_FAR_STATUS : `IDX_CFG, lvl[k]);
                rg("rise", `IDX_INT_STATUS, expSt);
                alarms[k] <= 1'b0;
                repeat (3) @(posedge clk);
                ev(k + 3);
                rg("fall", `IDX_INT_STATUS, expSt);
            end
        $display("test alarms done");
        syncBypass <= 1'b0;
        cbitParity <= 1'b1;
        acq();
        for (int i = 0; i < 66; i++)
        begin
            xs();
            f = seed[2:0];
            u_far.frame({1'b0, (i == 0), (i == 0), (i < 63), f});
            if (i == 0 || i == 62 || i == 64)
                ev(i == 0 ? `EV_CP : `EV_AIC);
            if (i == 0)
                ev(`EV_PERR);
            if (i > 60)
                rg("far", `IDX_FAR_STATUS, {4'h0, (i == 62 || i == 63), f});
        end
        rg("frame ev", `IDX_INT_STATUS, expSt);
        cbitParity <= 1'b0;
        u_far.frame({3'b001, 1'b0, ~f});
        rg("no cbit", `IDX_FAR_STATUS, {5'h0, f});
        rg("no cp", `IDX_INT_STATUS, expSt);
        $display("test frame fields done");
        // E3 mode: the P check and the M criterion must both give way.
        e3Mode <= 1'b1;
        bus(1'b1, `IDX_CFG, 8'h05);
        repeat (6)
            u_far.fbit(1'b1);
        waitOof(1'b1);
        acq();
        for (int i = 0; i < 5; i++)
            u_far.frame(7'h40);
        repeat (4) @(posedge clk);
        note("e3 m", {31'h0, outOfFrame}, 32'h0);
        rg("e3 ev", `IDX_INT_STATUS, expSt);
        e3Mode <= 1'b0;
        $display("test e3 done");
        summarize();
    end
endmodule
